//--- ese_defs.svh
// Constants for the exception syndrome encoder: field positions, codes, register offsets.
// Assumes inclusion by bare name from the package and design files.
`ifndef ESE_DEFS_SVH
`define ESE_DEFS_SVH
`define ESE_IL_BIT 25
`define ESE_SYN_W 25
`define ESE_EC_LSB 26
`define ESE_EC_W 6
`define ESE_EC_UNKNOWN 6'h00
`define ESE_EC_WAIT 6'h01
`define ESE_EC_FPACC 6'h07
`define ESE_PREDICATE_CODE_AL 4'he
`define ESE_REG_PC32 4'hf
`define ESE_REG_ZR 5'h1f
`define ESE_TI_WFI 2'h0
`define ESE_TI_WFE 2'h1
`define ESE_TI_WFIT 2'h2
`define ESE_TI_WFET 2'h3
`define ESE_PV_BIT 24
`define ESE_PC_MSB 23
`define ESE_PC_LSB 20
`define ESE_RN_MSB 9
`define ESE_RN_LSB 5
`define ESE_RV_BIT 2
`define ESE_TI_MSB 1
`define ESE_EL2 2'h2
`define ESE_EL3 2'h3
`define ESE_OFF_SYN_LO 12'h000
`define ESE_OFF_SYN_HI 12'h004
`define ESE_OFF_CTRL 12'h008
`define ESE_OFF_STAT 12'h00c
`define ESE_RESP_OK 2'h0
`define ESE_RESP_SLVERR 2'h2
`define ESE_CTRL_W 3
`endif

//--- ese_pkg.sv
// Types for the exception syndrome encoder.
// Assumes ese_defs.svh is on the include path.
`include "ese_defs.svh"
package ese_pkg;
	typedef enum logic [1:0] {
		ESE_ST_A64 = 2'h0,
		ESE_ST_FIXED32 = 2'h1,
		ESE_ST_COMPACT32 = 2'h2
	} ese_state_e;
	typedef enum logic [2:0] {
		ESE_AX_IDLE = 3'b001,
		ESE_AX_WRESP = 3'b010,
		ESE_AX_RRESP = 3'b100
	} ese_axi_e;
endpackage

//--- ese_unknown_detect.sv
// Detects conditions that raise the unknown-reason class.
// Assumes all inputs are decoded by the core pipeline in the same clock domain.
`timescale 1ns/1ns
`include "ese_defs.svh"
module ese_unknown_detect
	import ese_pkg::*;
(
	// Decode status
	input wire logic i_unallocated,
	input wire logic i_unimplemented,
	input wire logic i_sysreg_denied,
	input wire logic i_debug_state,
	input wire logic i_pattern_bad_for_state,
	input wire logic i_short_vector_fp,
	input wire logic i_fp_access,
	input wire logic i_fp_present,
	// Special instructions
	input wire logic i_hyp_call,
	input wire logic i_hyp_call_disable,
	input wire logic i_hyp_call_enable,
	input wire logic i_monitor_call,
	input wire logic i_monitor_call_disable,
	input wire logic i_halt_instr,
	input wire logic i_halting_enable,
	input wire logic i_sp0_access,
	input wire logic i_stack_select,
	input wire logic i_el12_access,
	input wire logic i_host_extension,
	input wire logic i_dcl_one,
	input wire logic i_dcl_two,
	input wire logic i_dcl_three,
	input wire logic [1:0] i_cur_el,
	input wire logic i_el2_enabled,
	input wire logic i_el3_present,
	input wire logic i_trap_general,
	input wire logic i_secure_debug_disable,
	input wire logic i_trap_to_el3,
	input wire logic i_banked_monitor,
	input wire logic i_monitor_stack_srs,
	input wire logic i_transaction_end,
	input wire logic i_in_transaction,
	input wire logic i_ctrl_bits_fault,
	// Result
	output logic o_unknown
);
	logic dcl_bad;
	always_comb begin
		dcl_bad = i_debug_state & (
			(i_dcl_one & i_trap_general & ~i_el2_enabled) |
			(i_dcl_two & (i_cur_el < `ESE_EL2) & ~i_el2_enabled) |
			(i_dcl_three & (i_secure_debug_disable | ~i_el3_present))); // RULE13
		o_unknown = i_unallocated | i_unimplemented | i_sysreg_denied // RULE8
			| i_pattern_bad_for_state | i_short_vector_fp // RULE9
			| (i_fp_access & ~i_fp_present) // RULE10
			| (i_hyp_call & (i_hyp_call_disable | ~i_hyp_call_enable)) // RULE11
			| (i_monitor_call & i_monitor_call_disable) | (i_halt_instr & ~i_halting_enable) // RULE11
			| (i_sp0_access & ~i_stack_select) | (i_el12_access & ~i_host_extension) // RULE12
			| dcl_bad
			| (i_debug_state & i_secure_debug_disable & i_trap_to_el3 & (i_cur_el != `ESE_EL3)) // RULE14
			| i_banked_monitor | i_monitor_stack_srs // RULE16
			| (i_transaction_end & ~i_in_transaction) // RULE17
			| i_ctrl_bits_fault;
	end
endmodule

//--- ese_syndrome_encoder.sv
// Operation
// RULE1: Bit 25 is instruction width; 16-bit trapped instruction writes zero.
// RULE2: Width bit is one for errors, aborts, alignment, illegal state, most debug.
// RULE3: Class syndrome sits in bits 24..0, layout picked by class.
// RULE4: Register numbers are reported in 64-bit numbering.
// RULE5: Well-defined 32-bit specifier 15 reports register number 31.
// RULE6: Unpredictable specifier 15 reports a usable register or 31.
// RULE7: Unknown class clears bits 24..0 and sets width bit.
// RULE8: Unallocated, unimplemented or denied system access gives unknown class.
// RULE9: Patterns barred in debug state or short vectors give unknown class.
// RULE10: Without vector/FP hardware, such accesses give unknown class.
// RULE11: Disabled hypervisor, monitor or halt instructions give unknown class.
// RULE12: Level-0 stack pointer or alias access when disabled gives unknown.
// RULE13: Debug change-level instructions barred by level config give unknown.
// RULE14: Debug with secure debug off, trap-to-level-3 gives unknown class.
// RULE15: Trap-general redirect of FP-access class to level 2 gives unknown.
// RULE16: Banked moves to monitor registers give unknown class.
// RULE17: Transaction end outside a transaction gives unknown class.
// RULE18: Wait trap bit 24 is predicate valid; one for 64-bit and fixed-width.
// RULE19: Predicate code in bits 23..20; 64-bit state writes 0xe.
// RULE20: Fixed-width reports own condition, or 0xe if unconditional.
// RULE21: Compact set choice selects clear valid or reported condition.
// RULE22: Bits 9..5 hold timed wait register; reserved bits read zero.
// RULE23: Bits 1..0 encode which wait instruction trapped.
// RULE24: Bit 2 flags a valid register field for timed waits.
// RULE25: Width flag and all subfields update in the same cycle.
//
// Syndrome encoder with an AXI4-Lite view of the captured syndrome.
// Assumes the core pulses i_take for one cycle per synchronous exception.
//
// Decided for this implementation: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ns
`include "ese_defs.svh"
module ese_syndrome_encoder
	import ese_pkg::*;
#(
	parameter bit TIMED_WAIT_SUPPORT = 1'b1,
	parameter bit COMPACT_REPORTS_PREDICATE_CODE = 1'b1
)
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// Exception event
	input wire logic i_take,
	input wire logic [5:0] i_class,
	input wire logic i_instr16,
	input wire logic i_width_forced_one,
	input wire logic [1:0] i_exec_state,
	input wire logic i_route_el2,
	// Wait trap details
	input wire logic [1:0] i_wait_kind,
	input wire logic i_conditional,
	input wire logic [3:0] i_predicate_code,
	input wire logic [4:0] i_wait_reg64,
	input wire logic [3:0] i_wait_reg32,
	input wire logic i_unpredictable,
	// Unknown-reason causes
	input wire logic i_unallocated,
	input wire logic i_unimplemented,
	input wire logic i_sysreg_denied,
	input wire logic i_debug_state,
	input wire logic i_pattern_bad_for_state,
	input wire logic i_short_vector_fp,
	input wire logic i_fp_access,
	input wire logic i_fp_present,
	input wire logic i_hyp_call,
	input wire logic i_hyp_call_disable,
	input wire logic i_hyp_call_enable,
	input wire logic i_monitor_call,
	input wire logic i_monitor_call_disable,
	input wire logic i_halt_instr,
	input wire logic i_halting_enable,
	input wire logic i_sp0_access,
	input wire logic i_stack_select,
	input wire logic i_el12_access,
	input wire logic i_host_extension,
	input wire logic i_dcl_one,
	input wire logic i_dcl_two,
	input wire logic i_dcl_three,
	input wire logic [1:0] i_cur_el,
	input wire logic i_el2_enabled,
	input wire logic i_el3_present,
	input wire logic i_trap_general,
	input wire logic i_secure_debug_disable,
	input wire logic i_trap_to_el3,
	input wire logic i_banked_monitor,
	input wire logic i_monitor_stack_srs,
	input wire logic i_transaction_end,
	input wire logic i_in_transaction,
	input wire logic i_ctrl_bits_fault,
	// Syndrome out
	output logic [31:0] o_syndrome,
	output logic o_syndrome_valid,
	// AXI4-Lite slave
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	typedef struct packed {
		logic [63:0] syn;
		logic valid;
		logic [31:0] count;
		logic [`ESE_CTRL_W-1:0] ctrl;
		ese_axi_e wst;
		logic aw_got;
		logic [11:0] awaddr;
		logic w_got;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic [1:0] bresp;
		ese_axi_e rst;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} ese_state_s;

	ese_state_s st_reg;
	ese_state_s st_next;
	logic unknown;
	logic [5:0] eff_class;
	logic [24:0] wait_syn;
	logic [24:0] cls_syn;
	logic width_flag;

	function automatic logic [4:0] ese_map_reg(input logic [3:0] r32, input logic unpred);
		// Only the well-defined and the 0x1f choice are produced for specifier 15
		if (r32 == `ESE_REG_PC32) begin
			ese_map_reg = `ESE_REG_ZR; // RULE5 RULE6
		end else begin
			ese_map_reg = {1'b0, r32}; // RULE4
		end
	endfunction

	function automatic logic [3:0] ese_pred_code(input logic predicate_code_instr, input logic [3:0] code);
		// Unconditional instructions report the always code
		if (predicate_code_instr) begin
			ese_pred_code = code;
		end else begin
			ese_pred_code = `ESE_PREDICATE_CODE_AL;
		end
	endfunction

	function automatic logic [31:0] ese_wmask(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
		for (int i = 0; i < 4; i++) begin
			old[i*8 +: 8] = s[i] ? d[i*8 +: 8] : old[i*8 +: 8];
		end
		ese_wmask = old;
	endfunction

	ese_unknown_detect u_unknown (
		.i_unallocated(i_unallocated),
		.i_unimplemented(i_unimplemented),
		.i_sysreg_denied(i_sysreg_denied),
		.i_debug_state(i_debug_state),
		.i_pattern_bad_for_state(i_pattern_bad_for_state),
		.i_short_vector_fp(i_short_vector_fp),
		.i_fp_access(i_fp_access),
		.i_fp_present(i_fp_present),
		.i_hyp_call(i_hyp_call),
		.i_hyp_call_disable(i_hyp_call_disable),
		.i_hyp_call_enable(i_hyp_call_enable),
		.i_monitor_call(i_monitor_call),
		.i_monitor_call_disable(i_monitor_call_disable),
		.i_halt_instr(i_halt_instr),
		.i_halting_enable(i_halting_enable),
		.i_sp0_access(i_sp0_access),
		.i_stack_select(i_stack_select),
		.i_el12_access(i_el12_access),
		.i_host_extension(i_host_extension),
		.i_dcl_one(i_dcl_one),
		.i_dcl_two(i_dcl_two),
		.i_dcl_three(i_dcl_three),
		.i_cur_el(i_cur_el),
		.i_el2_enabled(i_el2_enabled),
		.i_el3_present(i_el3_present),
		.i_trap_general(i_trap_general),
		.i_secure_debug_disable(i_secure_debug_disable),
		.i_trap_to_el3(i_trap_to_el3),
		.i_banked_monitor(i_banked_monitor),
		.i_monitor_stack_srs(i_monitor_stack_srs),
		.i_transaction_end(i_transaction_end),
		.i_in_transaction(i_in_transaction),
		.i_ctrl_bits_fault(i_ctrl_bits_fault),
		.o_unknown(unknown)
	);

	// Class selection and syndrome layout
	always_comb begin
		eff_class = i_class;
		if (unknown) begin
			eff_class = `ESE_EC_UNKNOWN;
		end else if (i_trap_general & i_route_el2 & (i_class == `ESE_EC_FPACC)) begin
			eff_class = `ESE_EC_UNKNOWN; // RULE15
		end
		wait_syn = '0; // RULE22
		case (i_exec_state)
			ESE_ST_A64: begin
				wait_syn[`ESE_PV_BIT] = 1'b1; // RULE18
				wait_syn[`ESE_PC_MSB:`ESE_PC_LSB] = `ESE_PREDICATE_CODE_AL; // RULE19
			end
			ESE_ST_FIXED32: begin
				wait_syn[`ESE_PV_BIT] = 1'b1; // RULE18
				wait_syn[`ESE_PC_MSB:`ESE_PC_LSB] = ese_pred_code(i_conditional, i_predicate_code); // RULE20
			end
			default: begin
				// Compact set: condition that applied, always code when unconditional
				wait_syn[`ESE_PV_BIT] = COMPACT_REPORTS_PREDICATE_CODE; // RULE21
				if (COMPACT_REPORTS_PREDICATE_CODE) begin
					wait_syn[`ESE_PC_MSB:`ESE_PC_LSB] = ese_pred_code(i_conditional, i_predicate_code); // RULE21
				end
			end
		endcase
		if (TIMED_WAIT_SUPPORT) begin
			wait_syn[`ESE_TI_MSB:0] = i_wait_kind; // RULE23
			if (i_wait_kind[`ESE_TI_MSB]) begin
				wait_syn[`ESE_RV_BIT] = 1'b1; // RULE24
				if (i_exec_state == ESE_ST_A64) begin
					wait_syn[`ESE_RN_MSB:`ESE_RN_LSB] = i_wait_reg64; // RULE22
				end else begin
					wait_syn[`ESE_RN_MSB:`ESE_RN_LSB] = ese_map_reg(i_wait_reg32, i_unpredictable); // RULE4 RULE22
				end
			end
		end else begin
			wait_syn[0] = i_wait_kind[0]; // RULE23
		end
		case (eff_class)
			`ESE_EC_UNKNOWN: cls_syn = '0; // RULE7
			`ESE_EC_WAIT: cls_syn = wait_syn; // RULE3
			default: cls_syn = '0;
		endcase
		width_flag = ~i_instr16; // RULE1
		if (i_width_forced_one | (eff_class == `ESE_EC_UNKNOWN)) begin
			width_flag = 1'b1; // RULE2 RULE7
		end
	end

	// Next-state logic
	always_comb begin
		st_next = st_reg;
		if (i_take) begin
			st_next.syn[`ESE_EC_LSB +: `ESE_EC_W] = eff_class;
			st_next.syn[`ESE_IL_BIT] = width_flag; // RULE25
			st_next.syn[`ESE_SYN_W-1:0] = cls_syn; // RULE25
			st_next.syn[63:32] = '0;
			st_next.valid = 1'b1;
			st_next.count = st_reg.count + 32'h1;
		end
		// Write channel
		if (st_reg.wst == ESE_AX_IDLE) begin
			if (s_axi_awvalid & ~st_reg.aw_got) begin
				st_next.aw_got = 1'b1;
				st_next.awaddr = s_axi_awaddr;
			end
			if (s_axi_wvalid & ~st_reg.w_got) begin
				st_next.w_got = 1'b1;
				st_next.wdata = s_axi_wdata;
				st_next.wstrb = s_axi_wstrb;
			end
			if (st_reg.aw_got & st_reg.w_got) begin
				st_next.wst = ESE_AX_WRESP;
				st_next.aw_got = 1'b0;
				st_next.w_got = 1'b0;
				st_next.bresp = `ESE_RESP_OK;
				case (st_reg.awaddr)
					// Exception capture wins over a same-cycle write
					`ESE_OFF_SYN_LO: begin
						if (~i_take) begin
							st_next.syn[31:0] = ese_wmask(st_reg.syn[31:0], st_reg.wdata, st_reg.wstrb);
						end
					end
					`ESE_OFF_SYN_HI: begin
						if (~i_take) begin
							st_next.syn[63:32] = ese_wmask(st_reg.syn[63:32], st_reg.wdata, st_reg.wstrb);
						end
					end
					`ESE_OFF_CTRL: begin
						if (st_reg.wstrb[0] & st_reg.wdata[0] & ~i_take) begin
							st_next.valid = 1'b0;
						end
					end
					`ESE_OFF_STAT: begin
					end
					default: st_next.bresp = `ESE_RESP_SLVERR;
				endcase
			end
		end else if (s_axi_bready) begin
			st_next.wst = ESE_AX_IDLE;
		end
		// Read channel
		if (st_reg.rst == ESE_AX_IDLE) begin
			if (s_axi_arvalid) begin
				st_next.rst = ESE_AX_RRESP;
				st_next.rresp = `ESE_RESP_OK;
				case (s_axi_araddr)
					`ESE_OFF_SYN_LO: st_next.rdata = st_reg.syn[31:0];
					`ESE_OFF_SYN_HI: st_next.rdata = st_reg.syn[63:32];
					`ESE_OFF_CTRL: st_next.rdata = 32'h0;
					`ESE_OFF_STAT: st_next.rdata = {st_reg.count[30:0], st_reg.valid};
					default: begin
						st_next.rdata = 32'h0;
						st_next.rresp = `ESE_RESP_SLVERR;
					end
				endcase
			end
		end else if (s_axi_rready) begin
			st_next.rst = ESE_AX_IDLE;
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			st_reg <= '{syn: 64'h0, valid: 1'b0, count: 32'h0, ctrl: '0, wst: ESE_AX_IDLE, aw_got: 1'b0,
				awaddr: 12'h0, w_got: 1'b0, wdata: 32'h0, wstrb: 4'h0, bresp: 2'h0, rst: ESE_AX_IDLE,
				rdata: 32'h0, rresp: 2'h0};
		end else begin
			st_reg <= st_next;
		end
	end

	// Outputs
	assign o_syndrome = st_reg.syn[31:0];
	assign o_syndrome_valid = st_reg.valid;
	assign s_axi_awready = (st_reg.wst == ESE_AX_IDLE) & ~st_reg.aw_got;
	assign s_axi_wready = (st_reg.wst == ESE_AX_IDLE) & ~st_reg.w_got;
	assign s_axi_bvalid = (st_reg.wst == ESE_AX_WRESP);
	assign s_axi_bresp = st_reg.bresp;
	assign s_axi_arready = (st_reg.rst == ESE_AX_IDLE);
	assign s_axi_rvalid = (st_reg.rst == ESE_AX_RRESP);
	assign s_axi_rdata = st_reg.rdata;
	assign s_axi_rresp = st_reg.rresp;
endmodule

//--- ese_monitor.sv
// Concurrent checks on the syndrome encoder's exception-side ports.
// Assumes binding to ese_syndrome_encoder; one clock, async active-low reset.
`timescale 1ns/1ns
module ese_monitor
	import ese_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_take,
	input wire logic [5:0] i_class,
	input wire logic i_instr16,
	input wire logic i_width_forced_one,
	input wire logic [1:0] i_exec_state,
	input wire logic [1:0] i_wait_kind,
	input wire logic i_conditional,
	input wire logic [3:0] i_predicate_code,
	input wire logic [4:0] i_wait_reg64,
	input wire logic [3:0] i_wait_reg32,
	input wire logic i_unallocated,
	input wire logic [31:0] o_syndrome,
	input wire logic o_syndrome_valid
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rstn);
	// Result carries the wait class
	wire wok = o_syndrome[31:26] == 6'h01;
	sequence s_wait;
		i_take && i_class == 6'h01 && !i_unallocated;
	endsequence
	property p_unknown;
		i_take && i_unallocated |=> o_syndrome == 32'h02000000;
	endproperty
	a_unknown: assert property (p_unknown) else $error("unknown class syndrome wrong");
	property p_width16;
		i_take && i_instr16 && !i_width_forced_one |=> o_syndrome[31:26] == 6'h00 || !o_syndrome[25];
	endproperty
	a_width16: assert property (p_width16) else $error("width bit set for short instruction");
	property p_width1;
		i_take && i_width_forced_one |=> o_syndrome[25];
	endproperty
	a_width1: assert property (p_width1) else $error("forced width bit not one");
	property p_a64;
		s_wait ##0 (i_exec_state == ESE_ST_A64) |=> !wok || o_syndrome[24:20] == 5'h1e;
	endproperty
	a_a64: assert property (p_a64) else $error("64-bit predicate fields wrong");
	property p_fixed;
		s_wait ##0 (i_exec_state == ESE_ST_FIXED32) |=>
			!wok || o_syndrome[24:20] == {1'b1, $past(i_conditional) ? $past(i_predicate_code) : 4'he};
	endproperty
	a_fixed: assert property (p_fixed) else $error("fixed-width predicate wrong");
	property p_kind;
		s_wait |=> !wok || (o_syndrome[1:0] == $past(i_wait_kind) && o_syndrome[2] == o_syndrome[1]
			&& o_syndrome[19:10] == 10'h0 && o_syndrome[4:3] == 2'h0);
	endproperty
	a_kind: assert property (p_kind) else $error("wait kind or zero fields wrong");
	property p_rn64;
		s_wait ##0 (i_exec_state == ESE_ST_A64 && i_wait_kind[1]) |=>
			!wok || o_syndrome[9:5] == $past(i_wait_reg64);
	endproperty
	a_rn64: assert property (p_rn64) else $error("timed wait register wrong");
	property p_rn15;
		s_wait ##0 (i_exec_state != ESE_ST_A64 && i_wait_kind[1] && i_wait_reg32 == 4'hf) |=>
			!wok || o_syndrome[9:5] == 5'h1f;
	endproperty
	a_rn15: assert property (p_rn15) else $error("specifier 15 not reported as 31");
	property p_valid;
		i_take |=> o_syndrome_valid;
	endproperty
	a_valid: assert property (p_valid) else $error("valid not set with syndrome");
endmodule
bind ese_syndrome_encoder ese_monitor u_mon (.*);

//--- ese_syndrome_encoder_test.sv
// Self-checking bench for the syndrome encoder and its register view.
// Assumes the package, header and encoder compile first.
`timescale 1ns/1ns
module ese_syndrome_encoder_test;
	import ese_pkg::*;
	logic i_clk, i_rstn, i_take, i_instr16, i_width_forced_one, i_route_el2, i_conditional, i_unpredictable;
	logic [5:0] i_class;
	logic [1:0] i_exec_state, i_wait_kind, i_cur_el, s_axi_bresp, s_axi_rresp, r;
	logic [3:0] i_predicate_code, i_wait_reg32, s_axi_wstrb;
	logic [4:0] i_wait_reg64;
	logic i_unallocated, i_unimplemented, i_sysreg_denied, i_debug_state, i_pattern_bad_for_state;
	logic i_short_vector_fp, i_fp_access, i_fp_present, i_hyp_call, i_hyp_call_disable, i_hyp_call_enable;
	logic i_monitor_call, i_monitor_call_disable, i_halt_instr, i_halting_enable, i_sp0_access, i_stack_select;
	logic i_el12_access, i_host_extension, i_dcl_one, i_dcl_two, i_dcl_three, i_el2_enabled, i_el3_present;
	logic i_trap_general, i_secure_debug_disable, i_trap_to_el3, i_banked_monitor, i_monitor_stack_srs;
	logic i_transaction_end, i_in_transaction, i_ctrl_bits_fault, o_syndrome_valid;
	logic [31:0] o_syndrome, s_axi_wdata, s_axi_rdata, d;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [30:0] cnt;
	int err_total, compares;
	ese_syndrome_encoder u_ese_syndrome_encoder (.*);
	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end
	task chk(input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			err_total++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, s, e);
		end
	endtask
	task test_done;
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task tmo(input int n);
		if (n >= 50) begin
			err_total++;
			test_done;
		end
	endtask
	task dflt;
		{i_unallocated, i_unimplemented, i_sysreg_denied, i_debug_state, i_pattern_bad_for_state, i_short_vector_fp,
			i_fp_access, i_hyp_call, i_hyp_call_disable, i_monitor_call, i_monitor_call_disable, i_halt_instr,
			i_sp0_access, i_el12_access, i_dcl_one, i_dcl_two, i_dcl_three, i_trap_general, i_secure_debug_disable,
			i_trap_to_el3, i_banked_monitor, i_monitor_stack_srs, i_transaction_end, i_in_transaction,
			i_ctrl_bits_fault, i_route_el2, i_instr16, i_width_forced_one, i_conditional, i_unpredictable} <= '0;
		{i_fp_present, i_hyp_call_enable, i_halting_enable, i_stack_select, i_host_extension, i_el2_enabled,
			i_el3_present} <= 7'h7f;
		{i_cur_el, i_exec_state, i_wait_kind, i_predicate_code, i_wait_reg32, i_wait_reg64} <= '0;
	endtask
	task clr;
		@(posedge i_clk);
		dflt;
	endtask
	// One-cycle take, result checked the cycle after
	task exc(input logic [5:0] c, input logic [31:0] e);
		@(posedge i_clk);
		i_class <= c;
		i_take <= 1'b1;
		@(posedge i_clk);
		i_take <= 1'b0;
		cnt++;
		@(negedge i_clk);
		chk(o_syndrome, e);
		chk(o_syndrome_valid, 1);
	endtask
	function automatic logic [31:0] wx(input logic il, input logic [3:0] cd, input logic [4:0] rn,
		input logic [1:0] k);
		return {6'h01, il, 1'b1, cd, 10'h0, k[1] ? rn : 5'h0, 2'b0, k[1], k};
	endfunction
	task axw(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rs);
		int n;
		logic aw, w;
		n = 0;
		@(posedge i_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(negedge i_clk);
			aw = s_axi_awvalid && s_axi_awready;
			w = s_axi_wvalid && s_axi_wready;
			n++;
			@(posedge i_clk);
			if (aw) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
		end while ((s_axi_awvalid && !aw || s_axi_wvalid && !w) && n < 50);
		do begin
			@(negedge i_clk);
			n++;
		end while (!s_axi_bvalid && n < 50);
		rs = s_axi_bresp;
		tmo(n);
		@(posedge i_clk);
		s_axi_bready <= 1'b0;
	endtask
	task axr(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
		int n;
		n = 0;
		@(posedge i_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(negedge i_clk);
			n++;
		end while (!s_axi_arready && n < 50);
		@(posedge i_clk);
		s_axi_arvalid <= 1'b0;
		do begin
			@(negedge i_clk);
			n++;
		end while (!s_axi_rvalid && n < 50);
		v = s_axi_rdata;
		rs = s_axi_rresp;
		tmo(n);
		@(posedge i_clk);
		s_axi_rready <= 1'b0;
	endtask
	task t_unknown;
		for (int i = 0; i < 22; i++) begin
			clr;
			case (i)
				0: i_unallocated <= 1'b1;
				1: i_unimplemented <= 1'b1;
				2: i_sysreg_denied <= 1'b1;
				3: {i_debug_state, i_pattern_bad_for_state} <= 2'b11;
				4: i_short_vector_fp <= 1'b1;
				5: {i_fp_access, i_fp_present} <= 2'b10;
				6: {i_hyp_call, i_hyp_call_disable} <= 2'b11;
				7: {i_hyp_call, i_hyp_call_enable} <= 2'b10;
				8: {i_monitor_call, i_monitor_call_disable} <= 2'b11;
				9: {i_halt_instr, i_halting_enable} <= 2'b10;
				10: {i_sp0_access, i_stack_select} <= 2'b10;
				11: {i_el12_access, i_host_extension} <= 2'b10;
				12: {i_debug_state, i_dcl_one, i_trap_general, i_el2_enabled} <= 4'he;
				13: {i_debug_state, i_dcl_two, i_cur_el, i_el2_enabled} <= 5'h1a;
				14: {i_debug_state, i_dcl_three, i_secure_debug_disable} <= 3'h7;
				15: {i_debug_state, i_dcl_three, i_el3_present} <= 3'h6;
				16: {i_debug_state, i_secure_debug_disable, i_trap_to_el3, i_cur_el} <= 5'h1d;
				17: i_banked_monitor <= 1'b1;
				18: i_monitor_stack_srs <= 1'b1;
				19: {i_transaction_end, i_in_transaction} <= 2'b10;
				20: i_ctrl_bits_fault <= 1'b1;
				default: {i_route_el2, i_trap_general} <= 2'b11;
			endcase
			exc(i == 21 ? 6'h07 : 6'h01, 32'h02000000);
		end
		clr;
		{i_hyp_call, i_fp_access} <= 2'b11;
		exc(6'h01, wx(1'b1, 4'he, 5'h0, 2'h0));
		$display("unknown class test done");
	endtask
	task t_wait;
		for (int k = 0; k < 4; k++) begin
			clr;
			i_wait_kind <= k[1:0];
			i_wait_reg64 <= 5'h0c + k[4:0];
			exc(6'h01, wx(1'b1, 4'he, 5'h0c + k[4:0], k[1:0]));
		end
		clr;
		{i_exec_state, i_conditional, i_predicate_code, i_wait_kind, i_wait_reg32} <= {ESE_ST_FIXED32, 11'h4f5};
		exc(6'h01, wx(1'b1, 4'h3, 5'h05, 2'h3));
		clr;
		{i_exec_state, i_predicate_code, i_wait_kind} <= {ESE_ST_FIXED32, 6'h35};
		exc(6'h01, wx(1'b1, 4'he, 5'h0, 2'h1));
		clr;
		{i_exec_state, i_instr16, i_conditional, i_predicate_code, i_wait_kind, i_wait_reg32} <= {ESE_ST_COMPACT32, 12'heaf};
		exc(6'h01, wx(1'b0, 4'ha, 5'h1f, 2'h2));
		clr;
		{i_exec_state, i_instr16, i_width_forced_one, i_unpredictable} <= {ESE_ST_COMPACT32, 3'h7};
		{i_wait_kind, i_wait_reg32} <= 6'h3f;
		exc(6'h01, wx(1'b1, 4'he, 5'h1f, 2'h3));
		$display("wait class test done");
	endtask
	task t_regs;
		axr(12'h000, d, r);
		chk(d, wx(1'b1, 4'he, 5'h1f, 2'h3));
		axr(12'h00c, d, r);
		chk(d, {cnt, 1'b1});
		axw(12'h008, 32'h00000001, r);
		chk(o_syndrome_valid, 0);
		axw(12'h000, 32'h5a5a0f0f, r);
		axr(12'h000, d, r);
		chk(d, 32'h5a5a0f0f);
		axw(12'h004, 32'h0000abcd, r);
		chk(r, 0);
		axr(12'h004, d, r);
		chk(d, 32'h0000abcd);
		axr(12'h010, d, r);
		chk(d, 32'h0);
		chk(r, 2'h2);
		$display("register test done");
	endtask
	initial begin
		dflt;
		cnt = '0;
		{i_rstn, i_take, i_class, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= '0;
		s_axi_wstrb <= 4'hf;
		repeat (2) @(posedge i_clk);
		i_rstn <= 1'b1;
		@(negedge i_clk);
		chk(o_syndrome, 32'h0);
		chk(o_syndrome_valid, 1'b0);
		t_unknown;
		t_wait;
		t_regs;
		test_done;
	end
endmodule
